//--- hdl/gas_alarm_sequencer.v
// Warm-up, alarm, fault and analogue output sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`include "gas_alarm_regs.vh"

// Operation
// RL1 - Ignore gas until five minute warm-up ends
// RL2 - Green toggles each second during warm-up
// RL3 - Alarm: green steady on, red on
// RL4 - Buzzer only if link fitted, after delay
// RL5 - Relay energises once delay expires
// RL6 - Two links select 0/1/5/10 minute delay
// RL7 - Default delay setting is zero
// RL8 - Analogue output proportional to concentration
// RL9 - Fault: green off, red on
// RL10 - Current fault level two milliamps
// RL11 - Voltage fault 0.5 V or 1 V; output goes to 0 V on the 0-5 V and 0-10 V ranges
// RL12 - Buzzer link removed disables buzzer
// RL13 - Five selectable current and voltage ranges
// RL14 - Cancel pad short ends warm-up immediately
// RL15 - Alarm outputs clear when gas falls
// RL16 - Alarm at or above setpoint; timer restarts
module gas_alarm_sequencer #(
  parameter TICKS_PER_SEC = `SEC_NS / `CLK_PERIOD_NS,
  parameter CONC_W = 12
) (
  input wire core_clk,
  input wire rst_n,
  input wire [CONC_W-1:0] gas_conc,
  input wire sensor_fault,
  input wire buzzer_enable_link,
  input wire delay_select_low_link,
  input wire delay_select_high_link,
  input wire warmup_cancel_pad_a,
  input wire warmup_cancel_pad_b,
  output reg green_led,
  output reg red_led,
  output reg buzzer,
  output reg relay,
  output reg [11:0] aout_code,
  output reg irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_WARMUP = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam [9:0] WARMUP_S = `WARMUP_MIN * `SEC_PER_MIN;
  localparam [9:0] DLY1_S = `DLY1_MIN * `SEC_PER_MIN;
  localparam [9:0] DLY5_S = `DLY5_MIN * `SEC_PER_MIN;
  localparam [9:0] DLY10_S = `DLY10_MIN * `SEC_PER_MIN;

  reg state_q;
  reg [9:0] warm_cnt_q;
  reg [9:0] dly_cnt_q;
  reg [`CTRL_WIDTH-1:0] ctrl_q;
  reg [CONC_W-1:0] setpoint_q;
  reg [`EV_WIDTH-1:0] irq_stat_q;
  reg [`EV_WIDTH-1:0] irq_mask_q;
  reg alarm_q;
  reg fault_q;
  reg expired_q;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire sec_tick;

  tick_divider #(
    .DIV(TICKS_PER_SEC)
  ) u_sec (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_q(sec_tick)
  );

  // Delay selection: bus override or jumper links
  wire [1:0] dly_sel = ctrl_q[`CTRL_DLY_OVR] ?
    {ctrl_q[`CTRL_DLY_HI], ctrl_q[`CTRL_DLY_LO]} :
    {delay_select_high_link, delay_select_low_link};
  reg [9:0] dly_lim;
  always @*
  begin
    case (dly_sel) // RL6
      2'b00: dly_lim = 10'd0; // RL7
      2'b01: dly_lim = DLY1_S;
      2'b10: dly_lim = DLY5_S;
      2'b11: dly_lim = DLY10_S;
      default: dly_lim = 10'd0;
    endcase
  end

  wire cancel = warmup_cancel_pad_a | warmup_cancel_pad_b | ctrl_q[`CTRL_CANCEL];
  wire warm_end = (state_q == ST_WARMUP) &&
    (cancel || (sec_tick && warm_cnt_q == WARMUP_S - 10'd1)); // RL14
  wire alarm_d = (state_q == ST_RUN) && !sensor_fault &&
    (gas_conc >= setpoint_q); // RL1 RL16 RL15
  wire expired_d = alarm_d && (dly_cnt_q >= dly_lim);

  // Sequencing
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_WARMUP;
      warm_cnt_q <= 10'd0;
      dly_cnt_q <= 10'd0;
      alarm_q <= 1'b0;
      fault_q <= 1'b0;
      expired_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      fault_q <= sensor_fault;
      expired_q <= expired_d;
      case (state_q)
        ST_WARMUP:
        begin
          if (warm_end)
            state_q <= ST_RUN; // RL1
          else if (sec_tick)
            warm_cnt_q <= warm_cnt_q + 10'd1;
        end
        ST_RUN:
        begin
          state_q <= ST_RUN;
        end
        default:
        begin
          state_q <= ST_WARMUP;
        end
      endcase
      if (!alarm_d)
        dly_cnt_q <= 10'd0; // RL16
      else if (sec_tick && dly_cnt_q < dly_lim)
        dly_cnt_q <= dly_cnt_q + 10'd1;
    end
  end

  // Analogue output scaling
  wire [2:0] range = ctrl_q[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];
  wire live_zero = (range == `RANGE_4_20MA) || (range == `RANGE_1_5V) ||
    (range == `RANGE_2_10V) || (range > `RANGE_2_10V);
  wire [11:0] span = live_zero ? `AOUT_LIVE_SPAN : `AOUT_FULL_SPAN;
  wire [11:0] zero = live_zero ? `AOUT_LIVE_ZERO : `AOUT_ZERO;
  wire [11:0] conc12 = gas_conc[CONC_W-1 -: 12];
  wire [23:0] prod = conc12 * span;
  wire [12:0] sum = {1'b0, zero} + {1'b0, prod[23:12]};

  // Indicators and drive outputs
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      green_led <= 1'b0;
      red_led <= 1'b0;
      buzzer <= 1'b0;
      relay <= 1'b0;
      aout_code <= `AOUT_ZERO;
    end
    else
    begin
      if (sensor_fault)
      begin
        green_led <= 1'b0; // RL9
        red_led <= 1'b1;
      end
      else if (state_q == ST_WARMUP)
      begin
        red_led <= 1'b0;
        if (ctrl_q[`CTRL_NO_FLASH])
          green_led <= 1'b0;
        else if (sec_tick)
          green_led <= ~green_led; // RL2
      end
      else
      begin
        green_led <= 1'b1; // RL3
        red_led <= alarm_d; // RL3 RL15
      end
      buzzer <= expired_d && buzzer_enable_link; // RL4 RL12
      relay <= expired_d; // RL5
      if (sensor_fault && (range == `RANGE_0_5V || range == `RANGE_0_10V))
        aout_code <= `AOUT_ZERO;
      else if (sensor_fault)
        aout_code <= `AOUT_FAULT; // RL10 RL11
      else if (state_q == ST_WARMUP)
        aout_code <= zero;
      else
        aout_code <= sum[11:0]; // RL8 RL13
    end
  end

  // Register writes
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wval = wdata_q & wmask;
  wire [31:0] ctrl_new = ({24'h000000, ctrl_q} & ~wmask) | wval;
  wire [31:0] sp_new = ({{(32-CONC_W){1'b0}}, setpoint_q} & ~wmask) | wval;
  wire [31:0] mask_new = ({28'h0000000, irq_mask_q} & ~wmask) | wval;
  wire wr_map = (awaddr_q == `OFS_CTRL) || (awaddr_q == `OFS_SETPOINT) ||
    (awaddr_q == `OFS_STATUS) || (awaddr_q == `OFS_IRQ_STAT) ||
    (awaddr_q == `OFS_IRQ_MASK) || (awaddr_q == `OFS_CONC);
  wire [`EV_WIDTH-1:0] w1c = (do_write && awaddr_q == `OFS_IRQ_STAT) ?
    wval[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
  wire [`EV_WIDTH-1:0] events;
  assign events[`EV_ALARM] = alarm_d && !alarm_q;
  assign events[`EV_FAULT] = sensor_fault && !fault_q;
  assign events[`EV_WARM_DONE] = warm_end;
  assign events[`EV_DLY_DONE] = expired_d && !expired_q;

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      ctrl_q <= `CTRL_RST;
      setpoint_q <= `SETPOINT_RST;
      irq_mask_q <= `MASK_RST;
      irq_stat_q <= {`EV_WIDTH{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr_q == `OFS_CTRL)
          ctrl_q <= ctrl_new[`CTRL_WIDTH-1:0];
        if (awaddr_q == `OFS_SETPOINT)
          setpoint_q <= sp_new[CONC_W-1:0];
        if (awaddr_q == `OFS_IRQ_MASK)
          irq_mask_q <= mask_new[`EV_WIDTH-1:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      // Set wins over a simultaneous clear
      irq_stat_q <= (irq_stat_q & ~w1c) | events;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Register reads
  reg [31:0] rd_val;
  reg rd_hit;
  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFS_CTRL: rd_val[`CTRL_WIDTH-1:0] = ctrl_q;
      `OFS_SETPOINT: rd_val[CONC_W-1:0] = setpoint_q;
      `OFS_STATUS: rd_val[7:0] = {relay, buzzer, red_led, green_led,
        expired_q, fault_q, alarm_q, state_q};
      `OFS_IRQ_STAT: rd_val[`EV_WIDTH-1:0] = irq_stat_q;
      `OFS_IRQ_MASK: rd_val[`EV_WIDTH-1:0] = irq_mask_q;
      `OFS_CONC: rd_val[CONC_W-1:0] = gas_conc;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- hdl/tick_divider.v
// One-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module tick_divider #(
  parameter DIV = 40000000
) (
  input wire core_clk,
  input wire rst_n,
  output reg tick_q
);
  localparam CW = $clog2(DIV);
  reg [CW-1:0] cnt_q;

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= {CW{1'b0}};
      tick_q <= 1'b0;
    end
    else if (cnt_q == DIV[CW-1:0] - 1'b1)
    begin
      cnt_q <= {CW{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end
endmodule

//--- pkg/gas_alarm_regs.vh
// Register map, field positions, reset values and timing constants of the gas alarm sequencer
`ifndef GAS_ALARM_REGS_VH
`define GAS_ALARM_REGS_VH

`define OFS_CTRL 8'h00
`define OFS_SETPOINT 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_CONC 8'h14

`define CTRL_DLY_OVR 0
`define CTRL_DLY_LO 1
`define CTRL_DLY_HI 2
`define CTRL_NO_FLASH 3
`define CTRL_RANGE_LSB 4
`define CTRL_RANGE_MSB 6
`define CTRL_CANCEL 7
`define CTRL_WIDTH 8

`define CTRL_RST 8'h00
`define SETPOINT_RST 12'h800
`define MASK_RST 4'h0

`define EV_ALARM 0
`define EV_FAULT 1
`define EV_WARM_DONE 2
`define EV_DLY_DONE 3
`define EV_WIDTH 4

`define RANGE_4_20MA 3'h0
`define RANGE_0_5V 3'h1
`define RANGE_1_5V 3'h2
`define RANGE_0_10V 3'h3
`define RANGE_2_10V 3'h4

`define AOUT_LIVE_ZERO 12'h333
`define AOUT_LIVE_SPAN 12'hCCC
`define AOUT_FULL_SPAN 12'hFFF
`define AOUT_FAULT 12'h199
`define AOUT_ZERO 12'h000

`define CLK_PERIOD_NS 25
`define SEC_NS 1000000000
`define SEC_PER_MIN 60
`define WARMUP_MIN 5
`define DLY1_MIN 1
`define DLY5_MIN 5
`define DLY10_MIN 10

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- tb/gas_alarm_chk.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module gas_alarm_chk #(
  parameter TICKS_PER_SEC = 10
) (
  input logic core_clk,
  input logic rst_n,
  input logic sensor_fault,
  input logic buzzer_enable_link,
  input logic delay_select_low_link,
  input logic delay_select_high_link,
  input logic warmup_cancel_pad_a,
  input logic warmup_cancel_pad_b,
  input logic green_led,
  input logic red_led,
  input logic buzzer,
  input logic relay,
  input logic [11:0] aout_code,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  logic [15:0] cnt_q;
  logic [11:0] up_q;
  logic warm_q;
  logic pad;
  int lim;
  assign pad = warmup_cancel_pad_a | warmup_cancel_pad_b;
  assign lim = TICKS_PER_SEC * (delay_select_high_link ? (delay_select_low_link ? 600 : 300)
    : (delay_select_low_link ? 60 : 0));
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      up_q <= 12'h000;
      warm_q <= 1'h1;
    end
    else
    begin
      cnt_q <= (red_led & green_led) ? cnt_q + 16'h0001 : 16'h0000;
      up_q <= (up_q == 12'hFA0) ? up_q : up_q + 12'h001;
      warm_q <= warm_q & ~pad;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold;
    ##1 $stable(green_led) [*8] ##[1:2] $changed(green_led);
  endsequence
  property p_warm;
    warm_q && !pad && !sensor_fault && up_q < 12'hBAE |=> !red_led && !relay;
  endproperty
  a_warm: assert property (p_warm) else $error("alarm during warm-up");
  property p_flash;
    disable iff (!rst_n || !warm_q)
    $changed(green_led) && !sensor_fault && up_q > 12'h005 && up_q < 12'hBA4 |-> s_hold;
  endproperty
  a_flash: assert property (p_flash) else $error("green flash period wrong");
  property p_alarm;
    relay || buzzer |-> red_led && green_led;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm lamps wrong");
  property p_delay;
    $rose(relay) |-> int'(cnt_q) + TICKS_PER_SEC + 3 >= lim && int'(cnt_q) <= lim + 3;
  endproperty
  a_delay: assert property (p_delay) else $error("relay delay wrong");
  property p_fault_ind;
    sensor_fault |=> !green_led && red_led && !relay;
  endproperty
  a_fault_ind: assert property (p_fault_ind) else $error("fault lamps wrong");
  property p_fault_lvl;
    sensor_fault |=> aout_code == 12'h199 || aout_code == 12'h000;
  endproperty
  a_fault_lvl: assert property (p_fault_lvl) else $error("fault level wrong");
  property p_buz;
    !buzzer_enable_link |=> !buzzer;
  endproperty
  a_buz: assert property (p_buz) else $error("buzzer without link");
  property p_cancel;
    pad && !sensor_fault |-> ##[1:3] green_led ##1 green_led;
  endproperty
  a_cancel: assert property (p_cancel) else $error("warm-up not cancelled");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response held");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read data held");
endmodule

bind gas_alarm_sequencer gas_alarm_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) i_gas_alarm_chk (
  .core_clk, .rst_n, .sensor_fault, .buzzer_enable_link, .delay_select_low_link,
  .delay_select_high_link, .warmup_cancel_pad_a, .warmup_cancel_pad_b, .green_led,
  .red_led, .buzzer, .relay, .aout_code, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready);

//--- tb/gas_sensor_model.sv
// Sensing element model feeding concentration and fault flag
`timescale 1ns/1ps
module gas_sensor_model (
  input logic core_clk,
  input logic [11:0] conc_set,
  input logic fault_set,
  output logic [11:0] gas_conc,
  output logic sensor_fault
);
  always @(posedge core_clk)
  begin
    gas_conc <= conc_set;
    sensor_fault <= fault_set;
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the gas alarm sequencer
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] conc_set = 12'h000;
  logic fault_set = 1'h0;
  logic [11:0] gas_conc, aout_code;
  logic sensor_fault, green_led, red_led, buzzer, relay, irq;
  logic buzzer_enable_link = 1'h1;
  logic delay_select_low_link = 1'h0;
  logic delay_select_high_link = 1'h0;
  logic warmup_cancel_pad_a = 1'h0;
  logic warmup_cancel_pad_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h02D4;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  always #12.5 core_clk = ~core_clk;
  gas_sensor_model i_gas_sensor_model (.core_clk, .conc_set, .fault_set, .gas_conc,
    .sensor_fault);
  gas_alarm_sequencer #(.TICKS_PER_SEC(10)) i_gas_alarm_sequencer (.core_clk, .rst_n,
    .gas_conc, .sensor_fault, .buzzer_enable_link, .delay_select_low_link,
    .delay_select_high_link, .warmup_cancel_pad_a, .warmup_cancel_pad_b, .green_led,
    .red_led, .buzzer, .relay, .aout_code, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Live-zero ranges are 4-20 mA, 1-5 V, 2-10 V and the spare codes
  function automatic [11:0] exp_aout(input [2:0] rg, input [11:0] c, input f);
    logic lz;
    begin
      lz = !(rg == 3'h1 || rg == 3'h3);
      if (f)
        exp_aout = lz ? 12'h199 : 12'h000;
      else if (lz)
        exp_aout = 12'h333 + 12'(({12'h000, c} * 24'h000CCC) >> 12);
      else
        exp_aout = 12'(({12'h000, c} * 24'h000FFF) >> 12);
    end
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(40000);
    mismatches++;
    wrap_up;
  end
  initial
  begin
    cyc(3);
    rst_n <= 1'h1;
    axr(8'h00);
    chk(32'h0, rd, "ctrl");
    axr(8'h04);
    chk(32'h800, rd, "setpoint");
    axr(8'h18);
    chk(2'h2, rs, "rresp");
    axw(8'h18, 32'h1);
    chk(2'h2, rs, "bresp");
    axw(8'h10, 32'h1);
    conc_set <= 12'hFFF;
    $display("register test done");
    cyc(2800);
    chk(2'h0, {red_led, relay}, "warm");
    cyc(300);
    chk(4'hF, {green_led, red_led, buzzer, relay}, "alarm");
    chk(1'h1, irq, "irq");
    axw(8'h0C, 32'h1);
    cyc(3);
    chk(1'h0, irq, "irq clear");
    $display("warm-up test done");
    repeat (24)
    begin
      seed = lfsr(seed);
      conc_set <= seed[11:0];
      buzzer_enable_link <= seed[12];
      cyc(4);
      n = seed[11:0] >= 12'h800;
      chk({1'h1, n[0], n[0] & seed[12], n[0]}, {green_led, red_led, buzzer, relay},
        "lamps");
      chk(exp_aout(3'h0, seed[11:0], 1'h0), aout_code, "aout");
    end
    axw(8'h10, 32'h0);
    cyc(2);
    chk(1'h0, irq, "irq mask");
    for (int rg = 0; rg < 5; rg++)
    begin
      axw(8'h00, rg << 4);
      fault_set <= 1'h1;
      cyc(4);
      chk(exp_aout(rg[2:0], 12'h0, 1'h1), aout_code, "fault level");
      chk(2'h1, {green_led, red_led}, "fault lamps");
      fault_set <= 1'h0;
      cyc(4);
      chk(exp_aout(rg[2:0], conc_set, 1'h0), aout_code, "range");
    end
    axw(8'h00, 32'h0);
    buzzer_enable_link <= 1'h1;
    $display("output test done");
    for (int k = 1; k < 4; k++)
    begin
      conc_set <= 12'h000;
      {delay_select_high_link, delay_select_low_link} <= k[1:0];
      cyc(4);
      conc_set <= 12'hFFF;
      cyc(300);
      conc_set <= 12'h000;
      cyc(3);
      conc_set <= 12'hFFF;
      n = 0;
      while (!relay && n < 7000)
      begin
        cyc(1);
        n++;
      end
      chk(2'h3, {buzzer, relay}, "delayed outputs");
      chk(1'h1, n + 15 >= (k == 1 ? 600 : k == 2 ? 3000 : 6000), "delay");
      chk(1'h1, n <= (k == 1 ? 615 : k == 2 ? 3015 : 6015), "delay max");
    end
    {delay_select_high_link, delay_select_low_link} <= 2'h0;
    $display("delay test done");
    for (int p = 0; p < 2; p++)
    begin
      rst_n <= 1'h0;
      cyc(2);
      rst_n <= 1'h1;
      cyc(20);
      {warmup_cancel_pad_b, warmup_cancel_pad_a} <= 2'h1 << p;
      cyc(1);
      {warmup_cancel_pad_b, warmup_cancel_pad_a} <= 2'h0;
      cyc(4);
      chk(3'h7, {green_led, red_led, relay}, "cancel");
    end
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    axw(8'h00, 32'h08);
    cyc(30);
    chk(1'h0, green_led, "no flash");
    axr(8'h08);
    chk(32'h00, rd, "status warm");
    warmup_cancel_pad_a <= 1'h1;
    cyc(1);
    warmup_cancel_pad_a <= 1'h0;
    cyc(4);
    axr(8'h08);
    chk(32'hFB, rd, "status run");
    $display("cancel test done");
    wrap_up;
  end
endmodule
